/* File: core/i2cm_top.v */
`timescale 1ns/10ps
`include "i2cm_map.vh"

// Function
// - Flag bits 0..7: rx data, rx ack, tx data, tx ack, start, restart, end, drop
// - Clock generator busy at flag bit 16, filter hit at bit 17
// - Each source has its own enable bit gating the interrupt request
// - Enable writes replace every enable bit in the byte lanes written, so clearing one bit means rewriting the others
// - Writing ones to the flag register clears those pending flags
// - Filter entries selected by index, enabled through their configuration word
// - Busy bit readable while the master performs a bus operation
// - Readable master status word shows current command state
// - Drop request moves master to drop state, abandoning bus activity
// - Start request moves master to start state, making a start condition
// - Restart during a transfer makes a repeated start without a stop
// - Pending start bit falls when the start sequence begins; software waits on it
// - Stop request during a transfer moves master to stop state, making a stop condition; in idle it retires with no stop
// - Pending stop bit falls when the stop sequence begins; software waits on it
// - Status: busy bit 0, start pending 4, stop pending 5, drop pending 6
// - Filter word: address bits 9..0, wide mode bit 14, enable bit 15
module i2cm_top #(
   parameter FILTERS = 4,
   parameter QTR_CYCLES = `I2CM_QTR_CYC
) (
   // System
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [7:0] awaddr,
   input wire [2:0] awprot,
   input wire awvalid,
   output reg awready,
   // AXI4-Lite write data
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   // AXI4-Lite write response
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // AXI4-Lite read address
   input wire [7:0] araddr,
   input wire [2:0] arprot,
   input wire arvalid,
   output reg arready,
   // AXI4-Lite read data
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // I2C clock line, open drain
   input wire scl_i,
   output reg scl_o,
   output reg scl_oe,
   // I2C data line, open drain
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe,
   // Interrupt request
   output reg irq
);

   localparam [5:0] ST_IDLE = 6'b000001;
   localparam [5:0] ST_START = 6'b000010;
   localparam [5:0] ST_ACTIVE = 6'b000100;
   localparam [5:0] ST_RESTART = 6'b001000;
   localparam [5:0] ST_STOP = 6'b010000;
   localparam [5:0] ST_DROP = 6'b100000;

   reg [5:0] st;
   reg [5:0] next_st;
   reg [1:0] phase;
   reg [1:0] next_phase;
   reg next_scl_oe;
   reg next_sda_oe;
   reg take_start;
   reg take_stop;
   reg take_drop;
   reg start_pend;
   reg stop_pend;
   reg drop_pend;
   reg [31:0] flag;
   reg [31:0] mask;
   reg [31:0] evt;
   reg [15:0] fcfg [0:FILTERS-1];
   reg [7:0] fsel;
   reg [FILTERS-1:0] fhit;
   reg frw;
   reg [FILTERS-1:0] next_fhit;
   reg [7:0] aw_addr;
   reg aw_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_held;
   reg [31:0] rd_mux;
   reg rd_ok;
   reg [31:0] wmask;
   reg [31:0] wval;
   reg busy_p;
   reg scl_p;
   reg sda_p;
   reg bus_act;
   reg [3:0] bit_cnt;
   reg [7:0] shift;
   reg first_byte;
   wire [1:0] line;
   wire scl_s;
   wire sda_s;
   wire tick;
   wire wr_go;
   wire busy;
   wire start_cond;
   wire stop_cond;
   wire scl_rise;
   wire [7:0] byte_now;
   integer i, j, k;

   ////////////////////////////////////////////////////////////////////////
   // Bus line sampling and condition detection

   i2cm_sync #(
      .WIDTH(2)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({scl_i, sda_i}),
      .dout(line)
   );

   assign scl_s = line[1];
   assign sda_s = line[0];
   assign start_cond = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_cond = scl_s & scl_p & ~sda_p & sda_s;
   assign scl_rise = scl_s & ~scl_p;
   assign byte_now = {shift[6:0], sda_s};
   assign busy = ~st[0];

   // Byte tracker on the observed bus: eight data bits then one ack bit
   always @(posedge aclk) begin
      if (!aresetn) begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
         bus_act <= 1'b0;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         first_byte <= 1'b0;
      end else begin
         scl_p <= scl_s;
         sda_p <= sda_s;
         if (start_cond) begin
            bus_act <= 1'b1;
            bit_cnt <= 4'h0;
            first_byte <= 1'b1;
         end else if (stop_cond) begin
            bus_act <= 1'b0;
         end else if (scl_rise && bus_act) begin
            if (bit_cnt == 4'h8) begin
               bit_cnt <= 4'h0;
               first_byte <= 1'b0;
            end else begin
               bit_cnt <= bit_cnt + 4'h1;
               shift <= byte_now;
            end
         end
      end
   end

   // First byte after a start compared with every enabled filter entry
   always @* begin
      next_fhit = {FILTERS{1'b0}};
      for (j = 0; j < FILTERS; j = j + 1) begin
         if (fcfg[j][`I2CM_FCFG_EN]) begin
            if (fcfg[j][`I2CM_FCFG_WIDE])
               next_fhit[j] = (byte_now[7:1] == {5'b11110, fcfg[j][9:8]});
            else
               next_fhit[j] = (byte_now[7:1] == fcfg[j][6:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Master command sequencer

   i2cm_tick #(
      .DIV(QTR_CYCLES)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(busy),
      .tick(tick)
   );

   // Next state; drop overrides everything and needs no tick to begin
   always @* begin
      next_st = st;
      next_phase = phase;
      take_start = 1'b0;
      take_stop = 1'b0;
      take_drop = 1'b0;
      case (st)
         ST_IDLE: begin
            if (drop_pend) begin
               next_st = ST_DROP;
               take_drop = 1'b1;
            end else if (start_pend) begin
               next_st = ST_START;
               take_start = 1'b1;
            end else if (stop_pend) begin
               take_stop = 1'b1; // Nothing to stop; request retires
            end
            next_phase = 2'd0;
         end
         ST_ACTIVE: begin
            next_phase = 2'd0;
            if (drop_pend) begin
               next_st = ST_DROP;
               take_drop = 1'b1;
            end else if (start_pend) begin
               next_st = ST_RESTART;
               take_start = 1'b1;
            end else if (stop_pend) begin
               next_st = ST_STOP;
               take_stop = 1'b1;
            end
         end
         ST_START, ST_RESTART, ST_STOP, ST_DROP: begin
            if (drop_pend && !st[5]) begin
               next_st = ST_DROP;
               next_phase = 2'd0;
               take_drop = 1'b1;
            end else if (tick) begin
               next_phase = phase + 2'd1;
               if (st[1] && phase == 2'd1)
                  next_st = ST_ACTIVE;
               else if (st[3] && phase == 2'd3)
                  next_st = ST_ACTIVE;
               else if (st[4] && phase == 2'd2)
                  next_st = ST_IDLE;
               else if (st[5])
                  next_st = ST_IDLE;
            end
         end
         default: begin
            next_st = ST_IDLE;
            next_phase = 2'd0;
         end
      endcase
   end

   // Line drive per state and quarter; an enable of one pulls the line low
   always @* begin
      next_scl_oe = 1'b0;
      next_sda_oe = 1'b0;
      case (next_st)
         ST_START: begin
            next_sda_oe = 1'b1;
            next_scl_oe = (next_phase == 2'd1);
         end
         ST_ACTIVE: next_scl_oe = 1'b1;
         ST_RESTART: begin
            next_scl_oe = next_phase[0] ^ ~next_phase[1];
            next_sda_oe = next_phase[1];
         end
         ST_STOP: begin
            next_sda_oe = (next_phase != 2'd2);
            next_scl_oe = (next_phase == 2'd0);
         end
         default: begin
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
         end
      endcase
   end

   // Sequencer registers; the pins only ever drive low
   always @(posedge aclk) begin
      if (!aresetn) begin
         st <= ST_IDLE;
         phase <= 2'd0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         busy_p <= 1'b0;
      end else begin
         st <= next_st;
         phase <= next_phase;
         scl_oe <= next_scl_oe;
         sda_oe <= next_sda_oe;
         busy_p <= busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt sources, flags and request

   // Master drives bytes it sends and samples the ack; otherwise the reverse
   always @* begin
      evt = 32'h0000_0000;
      evt[`I2CM_IRQ_RX_DATA] = scl_rise & bus_act & bit_cnt == 4'h7 & ~st[2];
      evt[`I2CM_IRQ_TX_DATA] = scl_rise & bus_act & bit_cnt == 4'h7 & st[2];
      evt[`I2CM_IRQ_RX_ACK] = scl_rise & bus_act & bit_cnt == 4'h8 & st[2];
      evt[`I2CM_IRQ_TX_ACK] = scl_rise & bus_act & bit_cnt == 4'h8 & ~st[2];
      evt[`I2CM_IRQ_START] = start_cond & ~bus_act;
      evt[`I2CM_IRQ_RESTART] = start_cond & bus_act;
      evt[`I2CM_IRQ_END] = stop_cond;
      evt[`I2CM_IRQ_DROP] = take_drop;
      evt[`I2CM_IRQ_CLKGEN] = busy & ~busy_p;
      evt[`I2CM_IRQ_FILTER] = scl_rise & bus_act & first_byte & bit_cnt == 4'h7
         & (|next_fhit);
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   assign wr_go = aw_held & w_held & ~bvalid;

   // Byte lanes expanded into a bit mask
   always @* begin
      wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
      wval = w_data & wmask;
   end

   // Address and data are taken independently, each into its own holder
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `I2CM_RESP_OKAY;
      end else begin
         awready <= awvalid & ~awready & ~aw_held;
         wready <= wvalid & ~wready & ~w_held;
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            case (aw_addr)
               `I2CM_ADDR_STATUS, `I2CM_ADDR_FLAG, `I2CM_ADDR_MASK,
               `I2CM_ADDR_FSEL, `I2CM_ADDR_FCFG, `I2CM_ADDR_FHIT:
                  bresp <= `I2CM_RESP_OKAY;
               default: bresp <= `I2CM_RESP_SLVERR;
            endcase
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Register writes; hardware sets win over software clears
   always @(posedge aclk) begin
      if (!aresetn) begin
         flag <= `I2CM_RST_FLAG;
         mask <= `I2CM_RST_MASK;
         start_pend <= 1'b0;
         stop_pend <= 1'b0;
         drop_pend <= 1'b0;
         fsel <= 8'h00;
         fhit <= {FILTERS{1'b0}};
         frw <= 1'b0;
         irq <= 1'b0;
         for (i = 0; i < FILTERS; i = i + 1)
            fcfg[i] <= 16'h0000;
      end else begin
         if (wr_go && aw_addr == `I2CM_ADDR_FLAG)
            flag <= ((flag & ~wval) | evt) & `I2CM_IRQ_VALID;
         else
            flag <= (flag | evt) & `I2CM_IRQ_VALID;
         if (wr_go && aw_addr == `I2CM_ADDR_MASK)
            mask <= ((mask & ~wmask) | wval) & `I2CM_IRQ_VALID;
         start_pend <= (start_pend & ~take_start)
            | (wr_go && aw_addr == `I2CM_ADDR_STATUS && wval[`I2CM_ST_START]);
         stop_pend <= (stop_pend & ~take_stop)
            | (wr_go && aw_addr == `I2CM_ADDR_STATUS && wval[`I2CM_ST_STOP]);
         drop_pend <= (drop_pend & ~take_drop)
            | (wr_go && aw_addr == `I2CM_ADDR_STATUS && wval[`I2CM_ST_DROP]);
         if (wr_go && aw_addr == `I2CM_ADDR_FSEL && w_strb[0])
            fsel <= w_data[7:0];
         if (wr_go && aw_addr == `I2CM_ADDR_FCFG) begin
            for (i = 0; i < FILTERS; i = i + 1)
               if (fsel == i[7:0])
                  fcfg[i] <= ((fcfg[i] & ~wmask[15:0]) | wval[15:0])
                     & `I2CM_FCFG_VALID;
         end
         if (evt[`I2CM_IRQ_FILTER]) begin
            fhit <= next_fhit;
            frw <= sda_s; // Direction bit of the matched address byte
         end
         irq <= |(flag & mask);
      end
   end

   // Read mux
   always @* begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b1;
      case (araddr)
         `I2CM_ADDR_STATUS: begin
            rd_mux[`I2CM_ST_BUSY] = busy;
            rd_mux[`I2CM_ST_START] = start_pend;
            rd_mux[`I2CM_ST_STOP] = stop_pend;
            rd_mux[`I2CM_ST_DROP] = drop_pend;
         end
         `I2CM_ADDR_FLAG: rd_mux = flag;
         `I2CM_ADDR_MASK: rd_mux = mask;
         `I2CM_ADDR_FSEL: rd_mux[7:0] = fsel;
         `I2CM_ADDR_FCFG: begin
            for (k = 0; k < FILTERS; k = k + 1)
               if (fsel == k[7:0])
                  rd_mux[15:0] = fcfg[k];
         end
         `I2CM_ADDR_FHIT: rd_mux = {frw, {(31 - FILTERS){1'b0}}, fhit};
         default: rd_ok = 1'b0;
      endcase
   end

   // Read channel: one read at a time, answered the cycle after acceptance
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `I2CM_RESP_OKAY;
      end else begin
         arready <= arvalid & ~arready & ~rvalid;
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_ok ? `I2CM_RESP_OKAY : `I2CM_RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule

/* File: core/i2cm_map.vh */
`ifndef I2CM_MAP_VH
`define I2CM_MAP_VH

// Register byte offsets
`define I2CM_ADDR_STATUS 8'h00
`define I2CM_ADDR_FLAG 8'h04
`define I2CM_ADDR_MASK 8'h08
`define I2CM_ADDR_FSEL 8'h0C
`define I2CM_ADDR_FCFG 8'h10
`define I2CM_ADDR_FHIT 8'h14

// Master status and command bits
`define I2CM_ST_BUSY 0
`define I2CM_ST_START 4
`define I2CM_ST_STOP 5
`define I2CM_ST_DROP 6

// Interrupt source bits
`define I2CM_IRQ_RX_DATA 0
`define I2CM_IRQ_RX_ACK 1
`define I2CM_IRQ_TX_DATA 2
`define I2CM_IRQ_TX_ACK 3
`define I2CM_IRQ_START 4
`define I2CM_IRQ_RESTART 5
`define I2CM_IRQ_END 6
`define I2CM_IRQ_DROP 7
`define I2CM_IRQ_CLKGEN 16
`define I2CM_IRQ_FILTER 17
`define I2CM_IRQ_VALID 32'h0003_00FF

// Filter entry fields
`define I2CM_FCFG_ADDR_HI 9
`define I2CM_FCFG_WIDE 14
`define I2CM_FCFG_EN 15
`define I2CM_FCFG_VALID 16'hC3FF

// Reset values
`define I2CM_RST_MASK 32'h0000_0000
`define I2CM_RST_FLAG 32'h0000_0000

// AXI responses
`define I2CM_RESP_OKAY 2'b00
`define I2CM_RESP_SLVERR 2'b10

// Timing: quarter of an SCL period
`define I2CM_CLK_MHZ 100
`define I2CM_QTR_NS 2500
`define I2CM_QTR_CYC ((`I2CM_QTR_NS * `I2CM_CLK_MHZ) / 1000)

`endif

/* File: core/i2cm_sync.v */
`timescale 1ns/10ps

module i2cm_sync #(
   parameter WIDTH = 2
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Asynchronous levels in, synchronised levels out
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] meta;

   // Two stages; the first one feeds only the second
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta <= {WIDTH{1'b1}};
         dout <= {WIDTH{1'b1}};
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

/* File: core/i2cm_tick.v */
`timescale 1ns/10ps

module i2cm_tick #(
   parameter DIV = 250
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Count while high, restart from zero while low
   input wire enable,
   // One-cycle pulse every DIV cycles
   output reg tick
);

   reg [15:0] cnt;

   // Restarting on idle keeps the first quarter of every sequence begun from idle full length
   always @(posedge aclk) begin
      if (!aresetn || !enable) begin
         cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt == DIV[15:0] - 16'h0001) begin
         cnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 16'h0001;
         tick <= 1'b0;
      end
   end

endmodule

/* File: dv/i2cm_chk.sv */
`timescale 1ns/10ps
`include "i2cm_map.vh"
module i2cm_chk #(
   parameter int QTR_CYCLES = 250
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Write channels
   input wire [7:0] awaddr,
   input wire awvalid,
   input wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   input wire wready,
   input wire [1:0] bresp,
   input wire bvalid,
   input wire bready,
   // Read channels
   input wire arvalid,
   input wire arready,
   input wire [31:0] rdata,
   input wire rvalid,
   input wire rready,
   // Line pulls and interrupt
   input wire scl_oe,
   input wire sda_oe,
   input wire irq
);
   localparam int QMAX = QTR_CYCLES + 3;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   // Keep the last write so its completion can be judged against what was asked
   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_addr <= 8'h00;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            wr_addr <= awaddr;
         end
         if (wvalid && wready) begin
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
      end
   end
   ////////////////////////////////////////
   // Bus handshakes
   property p_b_hold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_hold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   property p_aw_pulse;
      awready |=> !awready;
   endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than a pulse");
   property p_r_after;
      arvalid && arready |=> rvalid;
   endproperty
   a_r_after: assert property (p_r_after) else $error("read answer late");
   // Only the six mapped aligned words answer OKAY
   property p_bresp_map;
      $rose(bvalid) |-> (bresp == `I2CM_RESP_SLVERR) == (wr_addr > 8'h14 || wr_addr[1:0] != 2'b00);
   endproperty
   a_bresp_map: assert property (p_bresp_map) else $error("write response code wrong");
   ////////////////////////////////////////
   // Line sequences: start and restart pull SDA a quarter before SCL
   property p_start;
      $rose(sda_oe) && !scl_oe |-> !scl_oe [*2] ##[1:QMAX] scl_oe;
   endproperty
   a_start: assert property (p_start) else $error("start condition malformed");
   property p_stop;
      $fell(scl_oe) && sda_oe |-> sda_oe [*2] ##[1:QMAX] !sda_oe;
   endproperty
   a_stop: assert property (p_stop) else $error("stop condition malformed");
   property p_drop;
      $rose(bvalid) && wr_addr == `I2CM_ADDR_STATUS && wr_data[`I2CM_ST_DROP] && wr_strb[0]
         |-> ##[1:6] !scl_oe && !sda_oe;
   endproperty
   a_drop: assert property (p_drop) else $error("drop did not release the lines");
   ////////////////////////////////////////
   // Interrupt output against mask and flag writes
   property p_mask_off;
      $rose(bvalid) && wr_addr == `I2CM_ADDR_MASK && wr_data == 32'h0000_0000 && wr_strb == 4'hF
         |-> ##2 !irq [*2];
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("irq with all sources off");
   property p_flag_clear;
      $rose(bvalid) && wr_addr == `I2CM_ADDR_FLAG && wr_data == 32'hFFFF_FFFF && wr_strb == 4'hF
         |-> ##2 !irq;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("irq after clearing all");
   c_irq: cover property ($rose(irq));
   c_start: cover property ($rose(scl_oe));
   c_slverr: cover property ($rose(bvalid) && bresp == `I2CM_RESP_SLVERR);
endmodule

bind i2cm_top i2cm_chk #(.QTR_CYCLES(QTR_CYCLES)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
   .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
   .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rvalid(rvalid), .rready(rready), .scl_oe(scl_oe), .sda_oe(sda_oe), .irq(irq)
);

/* File: dv/i2cm_tgt.sv */
`timescale 1ns/10ps
module i2cm_tgt (
   // Design pulls
   input logic scl_oe,
   input logic sda_oe,
   // Frame request
   input logic go,
   input logic [7:0] frame_byte,
   // Wire levels and observation
   output logic scl,
   output logic sda,
   output logic frame_busy,
   output int n_start,
   output int n_stop
);
   logic om_scl;
   logic om_sda;
   logic [8:0] sh;
   ////////////////////////////////////////
   // Pull-ups win unless someone pulls
   assign scl = om_scl & ~scl_oe;
   assign sda = om_sda & ~sda_oe;
   initial begin
      om_scl = 1'b1;
      om_sda = 1'b1;
      frame_busy = 1'b0;
      n_start = 0;
      n_stop = 0;
   end
   // Another party's frame at a 160 ns clock; SCL stands still between frames
   always @(posedge go) begin
      frame_busy = 1'b1;
      sh = {frame_byte, 1'b0};
      om_sda = 1'b0;
      for (int i = 8; i >= 0; i--) begin
         #80 om_scl = 1'b0;
         #40 om_sda = sh[i];
         #40 om_scl = 1'b1;
      end
      #80 om_scl = 1'b0;
      #40 om_sda = 1'b0;
      #40 om_scl = 1'b1;
      #40 om_sda = 1'b1;
      #80 frame_busy = 1'b0;
   end
   // Count start and stop conditions seen on the wires
   always @(negedge sda) if (scl) n_start++;
   always @(posedge sda) if (scl) n_stop++;
endmodule

/* File: dv/i2c_master_control_irq_bench.sv */
`timescale 1ns/10ps
`include "i2cm_map.vh"
module i2c_master_control_irq_bench;
   typedef struct {
      logic wr;
      logic [7:0] addr;
      logic [31:0] data;
      logic [1:0] resp;
      logic [31:0] exp;
   } i2cm_row_t;
   localparam int QTR = 4;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go;
   logic awready, wready, bvalid, arready, rvalid, scl, sda, scl_o, sda_o, scl_oe, sda_oe;
   logic irq, fbusy;
   logic [7:0] awaddr, araddr, frame_byte;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [2:0] awprot, arprot;
   logic [1:0] bresp, rresp, r;
   int n_start, n_stop, s0, p0, n_errors, num_checks;
   i2cm_row_t rows [10];

   i2cm_top #(.QTR_CYCLES(QTR)) uut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda),
      .sda_o, .sda_oe, .irq);
   i2cm_tgt u_tgt (.scl_oe, .sda_oe, .go, .frame_byte, .scl, .sda, .frame_busy(fbusy),
      .n_start, .n_stop);

   always #5 aclk = ~aclk;
   ////////////////////////////////////////
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask
   // Both write channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awready === 1'b1 && !aw_ok) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !w_ok) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // Software waits on a status bit; the watchdog bounds it
   task automatic poll(input int b, input logic v);
      do rd(`I2CM_ADDR_STATUS); while (d[b] !== v);
   endtask
   task automatic frame(input logic [7:0] b);
      @(posedge aclk);
      frame_byte <= b;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do @(posedge aclk); while (fbusy);
      repeat (4) @(posedge aclk);
   endtask
   task automatic flags(input logic [31:0] m, input logic [31:0] e);
      rd(`I2CM_ADDR_FLAG);
      chk32(d & m, e);
   endtask
   task automatic report_and_stop;
      $display("n_errors %0d num_checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      #200_000;
      n_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      report_and_stop;
   end
   // Table rows first, then the hand-written sequences
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go} = 8'h00;
      {awaddr, araddr, frame_byte, wdata, wstrb, awprot, arprot} = 0;
      rows = '{'{1, `I2CM_ADDR_MASK, 32'hFFFF_FFFF, 2'b00, 0},
               '{0, `I2CM_ADDR_MASK, 0, 2'b00, 32'h0003_00FF},
               '{0, `I2CM_ADDR_FLAG, 0, 2'b00, 32'h0000_0000},
               '{1, `I2CM_ADDR_FSEL, 32'h0000_0002, 2'b00, 0},
               '{1, `I2CM_ADDR_FCFG, 32'hFFFF_FFFF, 2'b00, 0},
               '{0, `I2CM_ADDR_FCFG, 0, 2'b00, 32'h0000_C3FF},
               '{1, `I2CM_ADDR_FCFG, 32'h0000_8030, 2'b00, 0},
               '{0, `I2CM_ADDR_STATUS, 0, 2'b00, 32'h0000_0000},
               '{1, 8'h40, 32'h0000_0001, 2'b10, 0},
               '{0, 8'h40, 0, 2'b10, 32'h0000_0000}};
      repeat (20) @(posedge aclk);
      chk1(irq | scl_oe | sda_oe | scl_o | sda_o, 1'b0);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].data);
         else begin
            rd(rows[i].addr);
            chk32(d, rows[i].exp);
         end
         chk32({30'h0, r}, {30'h0, rows[i].resp});
      end
      // Foreign frame to entry 2, read bit set
      frame(8'h61);
      flags(32'hFFFF_FFFF, 32'h0002_0059);
      chk1(irq, 1'b1);
      rd(`I2CM_ADDR_FHIT);
      chk32(d, 32'h8000_0004);
      // Filter source switched off first, then every source, then the filter alone back on
      wr(`I2CM_ADDR_MASK, 32'h0001_00FF);
      rd(`I2CM_ADDR_MASK);
      chk32(d, 32'h0001_00FF);
      chk1(irq, 1'b1);
      wr(`I2CM_ADDR_MASK, 32'h0000_0000);
      repeat (3) @(posedge aclk);
      chk1(irq, 1'b0);
      wr(`I2CM_ADDR_MASK, 32'h0002_0000);
      repeat (3) @(posedge aclk);
      chk1(irq, 1'b1);
      wr(`I2CM_ADDR_FLAG, 32'h0002_0000);
      repeat (3) @(posedge aclk);
      chk1(irq, 1'b0);
      flags(32'hFFFF_FFFF, 32'h0000_0059);
      wr(`I2CM_ADDR_MASK, 32'h0003_00FF);
      wr(`I2CM_ADDR_FLAG, 32'hFFFF_FFFF);
      flags(32'hFFFF_FFFF, 32'h0000_0000);
      // Start, restart, stop
      s0 = n_start;
      p0 = n_stop;
      wr(`I2CM_ADDR_STATUS, 32'h0000_0010);
      poll(4, 1'b0);
      chk1(d[0], 1'b1);
      repeat (3 * QTR) @(posedge aclk);
      chk32(n_start, s0 + 1);
      wr(`I2CM_ADDR_STATUS, 32'h0000_0010);
      poll(4, 1'b0);
      repeat (5 * QTR) @(posedge aclk);
      chk32({n_start[15:0], n_stop[15:0]}, {s0[15:0] + 16'd2, p0[15:0]});
      flags(32'h0001_0030, 32'h0001_0030);
      wr(`I2CM_ADDR_STATUS, 32'h0000_0020);
      poll(5, 1'b0);
      poll(0, 1'b0);
      chk32(n_stop, p0 + 1);
      flags(32'h0000_0040, 32'h0000_0040);
      // Drop out of an owned bus
      wr(`I2CM_ADDR_STATUS, 32'h0000_0010);
      repeat (3 * QTR) @(posedge aclk);
      wr(`I2CM_ADDR_STATUS, 32'h0000_0040);
      poll(6, 1'b0);
      poll(0, 1'b0);
      chk1(scl_oe | sda_oe, 1'b0);
      flags(32'h0000_0080, 32'h0000_0080);
      wr(`I2CM_ADDR_FLAG, 32'hFFFF_FFFF);
      // Second reset mid-run brings the mask back
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`I2CM_ADDR_MASK);
      chk32(d, 32'h0000_0000);
      chk1(irq, 1'b0);
      report_and_stop;
   end
endmodule
